// ### design/cio_pkg.sv
// Package for the CPU I/O port signal block: constants and carrier types
package cio_pkg;
  localparam int CIO_NUM_PORTS = 8;
  localparam int CIO_SEL_W = 6;
  localparam int CIO_FUNC_W = 6;
  localparam int CIO_DATA_W = 18;
  localparam int CIO_PORT_IDX_W = 3;
  // Microstep length in clock cycles
  localparam int CIO_STEP_NS = 40;
  localparam int CIO_CLK_NS = 10;
  localparam int CIO_STEP_CYC = (CIO_STEP_NS + CIO_CLK_NS - 1) / CIO_CLK_NS;
  // Fixed pulse width in clock cycles, inside one microstep
  localparam int CIO_PULSE_NS = 20;
  localparam int CIO_PULSE_CYC = (CIO_PULSE_NS + CIO_CLK_NS - 1) / CIO_CLK_NS;
  // Reset value of a port register
  localparam logic [17:0] CIO_PORT_RST = 18'h00000;

  // One microstep command from the CPU sequencer
  typedef struct packed {
    logic xmit;
    logic read;
    logic [2:0] port_sel;
    logic [5:0] dev_sel;
    logic [5:0] func;
  } cio_step_t;

  // Step timer phases
  typedef enum logic [1:0] {
    CIO_PH_PULSE = 2'b01,
    CIO_PH_REST = 2'b10
  } cio_phase_t;
endpackage

// ### design/cio_port_reg.sv
// One I/O port register with inbound load and attention synchroniser
`timescale 1ns/10ps
`default_nettype none
module cio_port_reg
  import cio_pkg::*;
#(
  parameter int DATA_W = 18
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Load strobe and data from the CPU side
  input wire logic cpu_load,
  input wire logic [DATA_W-1:0] cpu_data,
  // Inbound read gate load
  input wire logic gate_load,
  input wire logic [DATA_W-1:0] inbound_data_n,
  // Attention request pins, active low, asynchronous
  input wire logic [2:0] attention_request_n,
  input wire logic [2:0] attn_clear,
  // Outputs
  output logic [DATA_W-1:0] outbound_data_lines,
  output logic [2:0] attn_flag
);
  // Port register and sync stages
  logic [DATA_W-1:0] data_reg;
  logic [DATA_W-1:0] in_s1_reg, in_s2_reg;
  logic [2:0] at_s1_reg, at_s2_reg, at_s3_reg, flag_reg;
  wire [DATA_W-1:0] data_next;
  wire [2:0] attn_fall;
  wire [2:0] flag_next;

  // Read gate wins over CPU load; inbound lines are active low
  assign data_next = gate_load ? ~in_s2_reg : (cpu_load ? cpu_data : data_reg);
  // Falling edge seen only after the second stage
  assign attn_fall = at_s3_reg & ~at_s2_reg;
  // Set beats clear so no pulse is lost
  assign flag_next = attn_fall | (flag_reg & ~attn_clear);

  // Two-stage synchronisers for pins
  always_ff @(posedge clk) begin
    if (rst) begin
      in_s1_reg <= '1;
      in_s2_reg <= '1;
      at_s1_reg <= 3'h7;
      at_s2_reg <= 3'h7;
      at_s3_reg <= 3'h7;
    end else begin
      in_s1_reg <= inbound_data_n;
      in_s2_reg <= in_s1_reg;
      at_s1_reg <= attention_request_n;
      at_s2_reg <= at_s1_reg;
      at_s3_reg <= at_s2_reg;
    end
  end

  // Register and flag update
  always_ff @(posedge clk) begin
    if (rst) begin
      data_reg <= DATA_W'(CIO_PORT_RST);
      flag_reg <= 3'h0;
    end else begin
      data_reg <= data_next;
      flag_reg <= flag_next;
    end
  end

  assign outbound_data_lines = data_reg;
  assign attn_flag = flag_reg;
endmodule
`default_nettype wire

// ### design/cio_ports.sv
// CPU side of the eight external I/O ports and their strobe timing
// How it works
// - Eight independent ports, each own signal set
// - Six-bit device select driven to all ports
// - Six-bit function code driven to all ports
// - Transmit select low on chosen port only
// - One transmit strobe per transmit microstep
// - Select, function stable across strobe; data follows a CPU load unless a read gate loads that port on the same edge
// - Read gate loads chosen port register
// - Sync pulse every microstep, always
// - Pulse widths fixed; levels follow steps
// - Device select active high; transmit select, strobes, gates active low
// - Port register shown on outbound lines
// - Attention pulse latches its interrupt flag
// - Master clear low drives all ports
`timescale 1ns/10ps
`default_nettype none
module cio_ports
  import cio_pkg::*;
#(
  parameter int NUM_PORTS = CIO_NUM_PORTS,
  parameter int DATA_W = CIO_DATA_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Microstep command from the sequencer, sampled at step start
  input wire cio_step_t step_cmd,
  output logic step_start,
  // CPU write into a port register
  input wire logic cpu_load,
  input wire logic [CIO_PORT_IDX_W-1:0] cpu_load_port,
  input wire logic [DATA_W-1:0] cpu_data,
  // Interrupt flag clear from the CPU, per port and kind
  input wire logic [NUM_PORTS*3-1:0] attn_clear,
  // Shared port outputs
  output logic [CIO_SEL_W-1:0] device_select_lines,
  output logic [CIO_FUNC_W-1:0] function_code_lines,
  output logic transmit_strobe_n,
  output logic step_sync_pulse_n,
  output logic master_clear_level_n,
  // Per-port outputs
  output logic [NUM_PORTS-1:0] transmit_select_level_n,
  output logic [NUM_PORTS-1:0] read_gate_pulse_n,
  output logic [NUM_PORTS*DATA_W-1:0] outbound_data_lines,
  // Per-port inbound pins, active low
  input wire logic [NUM_PORTS*DATA_W-1:0] inbound_data_n,
  input wire logic [NUM_PORTS*3-1:0] attention_request_n,
  // Latched interrupt flags: data in, data out, status
  output logic [NUM_PORTS*3-1:0] attn_flag
);
  // Step timer and held command
  logic [7:0] step_cnt_reg;
  cio_phase_t phase_reg;
  cio_step_t cmd_reg;
  logic pulse_reg;
  logic mc_reg;
  wire step_end;
  wire [7:0] step_cnt_next;
  wire [NUM_PORTS-1:0] port_hit;
  wire gate_now;

  // Step boundary once per microstep
  assign step_end = (step_cnt_reg == 8'(CIO_STEP_CYC - 1));
  assign step_cnt_next = step_end ? 8'h00 : step_cnt_reg + 8'h01;
  assign step_start = step_end;
  // Fixed pulse window at the head of each step, not programmable
  assign gate_now = pulse_reg;

  // Microstep counter and phase
  always_ff @(posedge clk) begin
    if (rst) begin
      step_cnt_reg <= 8'h00;
      phase_reg <= CIO_PH_REST;
      pulse_reg <= 1'b0;
      cmd_reg <= '0;
      mc_reg <= 1'b1;
    end else begin
      step_cnt_reg <= step_cnt_next;
      mc_reg <= 1'b0;
      // Command held for the whole step keeps lines stable under strobe
      if (step_end) begin
        cmd_reg <= step_cmd;
      end
      // Pulse starts one cycle into step, after lines settle
      if (step_end) begin
        pulse_reg <= 1'b0;
        phase_reg <= CIO_PH_REST;
      end else if (step_cnt_reg == 8'h00) begin
        pulse_reg <= 1'b1;
        phase_reg <= CIO_PH_PULSE;
      end else if (step_cnt_reg == 8'(CIO_PULSE_CYC)) begin
        pulse_reg <= 1'b0;
        phase_reg <= CIO_PH_REST;
      end
    end
  end

  // Port decode from the port select field
  assign port_hit = NUM_PORTS'(1) << cmd_reg.port_sel;

  // Shared lines, polarity per signal kind
  assign device_select_lines = cmd_reg.dev_sel;
  assign function_code_lines = cmd_reg.func;
  assign transmit_strobe_n = ~(gate_now & cmd_reg.xmit);
  assign step_sync_pulse_n = ~gate_now;
  assign master_clear_level_n = ~mc_reg;
  // Level spans every consecutive transmit step without a gap
  assign transmit_select_level_n = ~(port_hit & {NUM_PORTS{cmd_reg.xmit & ~mc_reg}});
  assign read_gate_pulse_n = ~(port_hit & {NUM_PORTS{gate_now & cmd_reg.read}});

  // Load at the gate's end, when inbound data has settled
  wire gate_end = (step_cnt_reg == 8'(CIO_PULSE_CYC)) & cmd_reg.read;

  // One register per port
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PORTS; gi++) begin : g_port
      cio_port_reg #(.DATA_W(DATA_W)) u_port (
        .clk(clk),
        .rst(rst),
        .cpu_load(cpu_load && (cpu_load_port == CIO_PORT_IDX_W'(gi))),
        .cpu_data(cpu_data),
        .gate_load(gate_end && port_hit[gi]),
        .inbound_data_n(inbound_data_n[gi*DATA_W +: DATA_W]),
        .attention_request_n(attention_request_n[gi*3 +: 3]),
        .attn_clear(attn_clear[gi*3 +: 3]),
        .outbound_data_lines(outbound_data_lines[gi*DATA_W +: DATA_W]),
        .attn_flag(attn_flag[gi*3 +: 3])
      );
    end
  endgenerate

  // Checks
  AST_SYNC_ONCE: assert property (@(posedge clk) disable iff (rst)
    $fell(step_sync_pulse_n) |=> !step_sync_pulse_n [*1] ##1 step_sync_pulse_n)
    else $error("sync pulse width wrong");
  AST_STROBE_NEEDS_XMIT: assert property (@(posedge clk) disable iff (rst)
    !transmit_strobe_n |-> cmd_reg.xmit && !step_sync_pulse_n)
    else $error("strobe without transmit");
  AST_SEL_ONEHOT: assert property (@(posedge clk) disable iff (rst)
    $onehot0(~transmit_select_level_n))
    else $error("transmit select on many ports");
  AST_LINES_STABLE: assert property (@(posedge clk) disable iff (rst)
    !transmit_strobe_n && $past(!transmit_strobe_n) |-> $stable(device_select_lines)
    && $stable(function_code_lines))
    else $error("lines moved under strobe");
  AST_GATE_PORT: assert property (@(posedge clk) disable iff (rst)
    !read_gate_pulse_n[cmd_reg.port_sel] || read_gate_pulse_n == '1)
    else $error("read gate on wrong port");
  AST_SYNC_PERIOD: assert property (@(posedge clk) disable iff (rst)
    $fell(step_sync_pulse_n) |-> ##4 $fell(step_sync_pulse_n))
    else $error("sync period wrong");
  AST_FUNC_FOLLOWS: assert property (@(posedge clk) disable iff (rst)
    step_end |=> function_code_lines == $past(step_cmd.func))
    else $error("function code not taken");
  AST_DEV_FOLLOWS: assert property (@(posedge clk) disable iff (rst)
    step_end |=> device_select_lines == $past(step_cmd.dev_sel))
    else $error("device select not taken");
  AST_PHASE_MATCH: assert property (@(posedge clk) disable iff (rst)
    pulse_reg == (phase_reg == CIO_PH_PULSE))
    else $error("step phase and pulse disagree");
  AST_MC_RELEASE: assert property (@(posedge clk)
    rst ##1 !rst |=> master_clear_level_n)
    else $error("master clear stuck");
  COV_XMIT: cover property (@(posedge clk) !transmit_strobe_n);
  COV_READ: cover property (@(posedge clk) read_gate_pulse_n != '1);
  COV_XMIT_RUN: cover property (@(posedge clk)
    transmit_select_level_n != '1 [*8]);
endmodule
`default_nettype wire

// ### tb/cio_far_end.sv
// Model of the attached channel interface on the inbound data side
`timescale 1ns/10ps
`default_nettype none
module cio_far_end
  import cio_pkg::*;
(
  // Read gates from the CPU, one per port
  input wire logic [CIO_NUM_PORTS-1:0] read_gate_pulse_n,
  // Inbound pins and the true words behind them
  output logic [CIO_NUM_PORTS*CIO_DATA_W-1:0] inbound_data_n,
  output logic [CIO_NUM_PORTS*CIO_DATA_W-1:0] word
);
  // Words on offer, one per port
  logic [CIO_NUM_PORTS*CIO_DATA_W-1:0] words = {8{18'h2b4c7}};
  // Gate levels seen last time
  logic [CIO_NUM_PORTS-1:0] gate_prev = '1;
  assign word = words;
  // Pins are true low, so a 1 bit drives a low pin
  assign inbound_data_n = ~words;
  // Next word only once the gate has ended; held all through the gate
  always @(read_gate_pulse_n) begin
    for (int p = 0; p < CIO_NUM_PORTS; p++) begin
      if (!gate_prev[p] && read_gate_pulse_n[p]) begin
        words[p*18 +: 18] = {words[p*18 +: 17], ~^words[p*18+12 +: 6]};
      end
    end
    gate_prev = read_gate_pulse_n;
  end
endmodule
`default_nettype wire

// ### tb/cio_ports_tb_top.sv
// Self-checking bench for the CPU I/O port block
`timescale 1ns/10ps
`default_nettype none
module cio_ports_tb_top
  import cio_pkg::*;
;
  localparam int W = CIO_NUM_PORTS * CIO_DATA_W;
  // One noted step: command and expected port registers
  typedef struct packed {
    cio_step_t cmd;
    logic [W-1:0] regs;
  } cio_note_t;
  logic clk = 1'b0, rst = 1'b1, cpu_load = 1'b0, running = 1'b0;
  cio_step_t step_cmd = '0;
  logic [2:0] cpu_load_port = '0, rd_port = '0, ld_port = '0;
  logic [17:0] cpu_data = '0, rd_word = '0, ld_data = '0;
  logic [23:0] attn_clear = '0, attention_request_n = '1, attn_flag;
  logic step_start, transmit_strobe_n, step_sync_pulse_n, master_clear_level_n;
  logic [5:0] device_select_lines, function_code_lines;
  logic [7:0] transmit_select_level_n, read_gate_pulse_n;
  logic [W-1:0] outbound_data_lines, inbound_data_n, word, exp_regs = '0;
  logic [31:0] seed = 32'hd319ef9d;
  logic rd_pend = 1'b0, ld_pend = 1'b0, sp = 1'b1, sync_prev = 1'b1;
  logic [28:0] got_c, exp_c;
  cio_note_t q[$];
  cio_note_t n;
  int miscompares = 0, checks_done = 0;

  cio_ports DUT (.clk(clk), .rst(rst), .step_cmd(step_cmd), .step_start(step_start),
    .cpu_load(cpu_load), .cpu_load_port(cpu_load_port), .cpu_data(cpu_data),
    .attn_clear(attn_clear), .device_select_lines(device_select_lines),
    .function_code_lines(function_code_lines), .transmit_strobe_n(transmit_strobe_n),
    .step_sync_pulse_n(step_sync_pulse_n), .master_clear_level_n(master_clear_level_n),
    .transmit_select_level_n(transmit_select_level_n), .read_gate_pulse_n(read_gate_pulse_n),
    .outbound_data_lines(outbound_data_lines), .inbound_data_n(inbound_data_n),
    .attention_request_n(attention_request_n), .attn_flag(attn_flag));
  cio_far_end far (.read_gate_pulse_n(read_gate_pulse_n), .inbound_data_n(inbound_data_n),
    .word(word));

  // Free-running 100 MHz clock
  always #5 clk = ~clk;

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // Compare and count; no unknown passes
  task automatic chk(input logic [W-1:0] got, input logic [W-1:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict;
    if (miscompares == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Driver: notes each step taken, then sets up the next one
  always @(posedge clk) begin
    cpu_load <= 1'b0;
    // Load lands on the gate-end edge, so the read must win
    if (running && sp && step_sync_pulse_n === 1'b0) begin
      seed = lfsr(seed);
      ld_pend = seed[0];
      ld_port = seed[3:1];
      ld_data = seed[31:14];
      cpu_load <= ld_pend;
      cpu_load_port <= ld_port;
      cpu_data <= ld_data;
    end
    if (running && step_start === 1'b1) begin
      if (ld_pend) exp_regs[ld_port*18 +: 18] = ld_data;
      if (rd_pend) exp_regs[rd_port*18 +: 18] = rd_word;
      ld_pend = 1'b0;
      q.push_back('{step_cmd, exp_regs});
      rd_pend = step_cmd.read;
      rd_port = step_cmd.port_sel;
      rd_word = word[step_cmd.port_sel*18 +: 18];
      seed = lfsr(seed);
      step_cmd <= cio_step_t'(seed[16:0]);
    end
    sp <= step_sync_pulse_n;
  end

  // Checker: each sync fall closes the oldest noted step
  always @(negedge clk) begin
    if (sync_prev === 1'b1 && step_sync_pulse_n === 1'b0 && q.size() > 0) begin
      n = q.pop_front();
      got_c = {device_select_lines, function_code_lines, transmit_strobe_n,
        transmit_select_level_n, read_gate_pulse_n};
      exp_c = {n.cmd.dev_sel, n.cmd.func, ~n.cmd.xmit,
        ~(8'(n.cmd.xmit) << n.cmd.port_sel), ~(8'(n.cmd.read) << n.cmd.port_sel)};
      chk(W'(got_c), W'(exp_c));
      chk(outbound_data_lines, n.regs);
    end
    sync_prev = step_sync_pulse_n;
  end

  // Watchdog, well beyond the expected run
  initial begin
    #50000;
    miscompares++;
    give_verdict;
  end

  // Main sequence: reset, step traffic, then attention lines
  initial begin
    repeat (10) @(posedge clk);
    @(negedge clk);
    chk(outbound_data_lines, '0);
    chk(W'({master_clear_level_n, read_gate_pulse_n, transmit_select_level_n}), W'(17'h0ffff));
    @(posedge clk);
    rst <= 1'b0;
    running <= 1'b1;
    repeat (800) @(posedge clk);
    running <= 1'b0;
    repeat (12) @(posedge clk);
    for (int i = 0; i < 24; i++) begin
      attention_request_n[i] <= 1'b0;
      repeat (2) @(posedge clk);
      attention_request_n[i] <= 1'b1;
      repeat (6) @(negedge clk);
      chk(W'(attn_flag), W'(24'h1 << i));
      @(posedge clk);
      attn_clear[i] <= 1'b1;
      @(posedge clk);
      attn_clear[i] <= 1'b0;
      repeat (2) @(negedge clk);
      chk(W'(attn_flag), '0);
      @(posedge clk);
    end
    chk(W'(q.size()), '0);
    give_verdict;
  end
endmodule
`default_nettype wire
